// [inc/ibs_consts.vh]
// Constants for the instruction/data bus swap glue.
// Assumes inclusion by bare name from the design files.
`ifndef IBS_CONSTS_VH
`define IBS_CONSTS_VH
// =====================================================================
// Option code reserved for probe transfers
`define IBS_OPT_PROBE 3'h6
// Request type codes (data_request_type)
`define IBS_REQ_MEM 2'h0
`define IBS_REQ_IROM 2'h1
// =====================================================================
// Memory map: instruction ROM space and instruction/data RAM space
`define IBS_ROM_RAM_LIMIT 32'h00040000
`define IBS_MON_ROM_BASE 32'h00000000
`define IBS_MON_ROM_SIZE 32'h00040000
`define IBS_MON_RAM_BASE 32'h00000000
`define IBS_MON_RAM_SIZE 32'h00010000
// =====================================================================
// Wait states
`define IBS_WAIT_W 3
`define IBS_WAIT_MAX 3'h7
// Swap direction codes
`define IBS_DIR_I2D 1'b1
`define IBS_DIR_D2I 1'b0
`endif

// [rtl/ibs_swap_glue.v]
// Swap glue between instruction and data buses of a 32-bit processor.
// Assumes processor requests are synchronous to clk except the
// alignment pin, probe-driven lines and disable_source_select, which are synced.
`timescale 1ns/1ps
`default_nettype none
`include "ibs_consts.vh"
module ibs_swap_glue (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Processor data side requests
    input wire data_request_n,
    input wire [1:0] data_request_type,
    input wire data_read,
    input wire [31:0] data_address,
    input wire [2:0] option_code,
    // Processor instruction side requests
    input wire instruction_request_n,
    input wire instruction_request_type,
    input wire [31:0] instruction_address,
    // Probe-shared pins
    input wire align_pin,
    input wire [1:0] control_mode_lines_in,
    output reg [1:0] control_mode_lines_out,
    output reg [1:0] control_mode_lines_oe,
    // Straps and switches
    input wire disable_source_select,
    input wire [`IBS_WAIT_W-1:0] rom_waits,
    input wire [`IBS_WAIT_W-1:0] ram_waits,
    // Swap path, 32-bit
    input wire [31:0] ibus_in,
    input wire [31:0] dbus_in,
    output reg [31:0] ibus_out,
    output reg [31:0] dbus_out,
    output reg ibus_oe,
    output reg dbus_oe,
    output reg transceiver_enable,
    output reg transceiver_dir,
    // Memory controls
    output reg mem_enable,
    output reg rom_select,
    output reg ram_select,
    output reg [31:0] rom_address,
    output reg [31:0] ram_address,
    output reg rom_ready,
    output reg ram_ready,
    output reg mode_normal
);
    // =================================================================
    // Synchronisers for external levels
    // Reset values match the pulled-up idle levels, so no false
    // memory disable or mode change follows the release of reset
    reg align_s1_r, align_s2_r;
    reg sel_s1_r, sel_s2_r;
    reg [1:0] control_mode_lines_s1_r, control_mode_lines_s2_r;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            align_s1_r <= 1'b1;
            align_s2_r <= 1'b1;
            sel_s1_r <= 1'b0;
            sel_s2_r <= 1'b0;
            control_mode_lines_s1_r <= 2'h3;
            control_mode_lines_s2_r <= 2'h3;
        end else begin
            align_s1_r <= align_pin;
            align_s2_r <= align_s1_r;
            sel_s1_r <= disable_source_select;
            sel_s2_r <= sel_s1_r;
            control_mode_lines_s1_r <= control_mode_lines_in;
            control_mode_lines_s2_r <= control_mode_lines_s1_r;
        end
    end

    // =================================================================
    // Decode
    wire d_req = ~data_request_n;
    wire i_req = ~instruction_request_n;
    wire opt_probe = (option_code == `IBS_OPT_PROBE);
    // Select high decodes option, low watches align pin
    wire mem_dis = sel_s2_r ? (d_req & opt_probe)
                            : ~align_s2_r;
    // Data side targets ROM space when the type says so
    wire d_rom = d_req & (data_request_type == `IBS_REQ_IROM);
    wire d_ram = d_req & (data_request_type == `IBS_REQ_MEM);
    // Instruction fetch type: high means RAM space
    wire i_ram = i_req & instruction_request_type;
    wire i_rom = i_req & ~instruction_request_type;
    // RAM in ROM space is limited; beyond the limit is not decoded
    wire d_rom_ok = d_rom &
        (data_address < `IBS_ROM_RAM_LIMIT);
    wire i_rom_ok = i_rom &
        (instruction_address < `IBS_ROM_RAM_LIMIT);
    wire sw_i2d = d_rom_ok & data_read & ~mem_dis;
    // A RAM-space instruction fetch wins over a data write to ROM space
    wire sw_d2i = i_ram & ~mem_dis & ~sw_i2d;
    wire sw_wr = d_rom_ok & ~data_read & ~mem_dis & ~i_ram;

    // =================================================================
    // Wait-state generators, one per space
    reg rom_start_r, ram_start_r;
    reg rom_act_r, ram_act_r;
    wire rom_act = (d_rom_ok | i_rom_ok) & ~mem_dis;
    wire ram_act = (d_ram | i_ram) & ~mem_dis;
    wire rom_rdy, ram_rdy;
    ibs_wait_gen u_rom_wait (
        .clk(clk), .rst(rst), .start(rom_start_r),
        .waits(rom_waits), .ready_r(rom_rdy)
    );
    ibs_wait_gen u_ram_wait (
        .clk(clk), .rst(rst), .start(ram_start_r),
        .waits(ram_waits), .ready_r(ram_rdy)
    );

    // =================================================================
    // Wait-state starts and ready pulses
    // A start fires only on the rising edge of a space's activity, so
    // back-to-back accesses need one idle cycle between them
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rom_act_r <= 1'b0;
            ram_act_r <= 1'b0;
            rom_start_r <= 1'b0;
            ram_start_r <= 1'b0;
            rom_ready <= 1'b0;
            ram_ready <= 1'b0;
        end else begin
            rom_act_r <= rom_act;
            ram_act_r <= ram_act;
            rom_start_r <= rom_act & ~rom_act_r;
            ram_start_r <= ram_act & ~ram_act_r;
            rom_ready <= rom_rdy;
            ram_ready <= ram_rdy;
        end
    end

    // =================================================================
    // Probe-shared mode lines
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            control_mode_lines_out <= 2'h0;
            control_mode_lines_oe <= 2'h0;
            mode_normal <= 1'b1;
        end else begin
            // Glue never drives the shared mode lines; pull-ups hold
            // them high so a probe can take over without contention
            control_mode_lines_out <= 2'h0;
            control_mode_lines_oe <= 2'h0;
            mode_normal <= &control_mode_lines_s2_r;
        end
    end

    // =================================================================
    // Memory enable and space selects
    // Selects drop together with the enable, so a probe word never
    // meets a memory that answers in the same cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_enable <= 1'b0;
            rom_select <= 1'b0;
            ram_select <= 1'b0;
        end else begin
            mem_enable <= ~mem_dis;
            rom_select <= rom_act;
            ram_select <= ram_act;
        end
    end

    // =================================================================
    // Memory addresses
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rom_address <= 32'h0;
            ram_address <= 32'h0;
        end else begin
            // Addresses pass untranslated so downloaded code is
            // found at its absolute address
            rom_address <= d_rom ? data_address
                                 : instruction_address;
            ram_address <= d_ram ? data_address
                                 : instruction_address;
        end
    end

    // =================================================================
    // Swap path
    // Data outputs fall back to zero when idle, so a stale word is
    // never waiting on a driver that is about to turn on again
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ibus_out <= 32'h0;
            dbus_out <= 32'h0;
            ibus_oe <= 1'b0;
            dbus_oe <= 1'b0;
            transceiver_enable <= 1'b0;
            transceiver_dir <= `IBS_DIR_D2I;
        end else begin
            // One direction at most; both released when idle
            transceiver_enable <= sw_i2d | sw_d2i | sw_wr;
            transceiver_dir <= sw_i2d ? `IBS_DIR_I2D
                                      : `IBS_DIR_D2I;
            dbus_oe <= sw_i2d;
            ibus_oe <= sw_d2i | sw_wr;
            dbus_out <= sw_i2d ? ibus_in : 32'h0;
            ibus_out <= (sw_d2i | sw_wr) ? dbus_in : 32'h0;
        end
    end
endmodule
`default_nettype wire

// [rtl/ibs_wait_gen.v]
// One wait-state generator for a memory space.
// Assumes start is a one-cycle pulse at the first cycle of an access.
`timescale 1ns/1ps
`default_nettype none
`include "ibs_consts.vh"
module ibs_wait_gen (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control
    input wire start,
    input wire [`IBS_WAIT_W-1:0] waits,
    // Result
    output reg ready_r
);
    reg [`IBS_WAIT_W-1:0] cnt_r;
    reg busy_r;
    // =================================================================
    // Counter: ready pulses after the chosen number of waits
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 3'h0;
            busy_r <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            ready_r <= 1'b0;
            if (start) begin
                if (waits == 3'h0) begin
                    ready_r <= 1'b1;
                    busy_r <= 1'b0;
                end else begin
                    cnt_r <= waits;
                    busy_r <= 1'b1;
                end
            end else if (busy_r) begin
                if (cnt_r == 3'h1) begin
                    ready_r <= 1'b1;
                    busy_r <= 1'b0;
                end
                cnt_r <= cnt_r - 3'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/ibs_bus_model.sv]
// Far side of the swap path: the processor's two 32-bit buses.
// Assumes the bench supplies the word that the far side puts on each bus.
`timescale 1ns/1ps
`default_nettype none
module ibs_bus_model (
    // Glue drive
    input wire logic ibus_oe, dbus_oe,
    input wire logic [31:0] ibus_out, dbus_out,
    // Far-side words
    input wire logic [31:0] ipat, dpat,
    // Resolved bus levels
    output logic [31:0] ibus_in, dbus_in
);
    // The glue wins only while it drives, so a stale word never shows
    assign ibus_in = ibus_oe ? ibus_out : ipat;
    assign dbus_in = dbus_oe ? dbus_out : dpat;
endmodule
`default_nettype wire

// [tb/ibs_glue_monitor.sv]
// Port-level timing relations of the swap glue.
// Assumes it is bound to every instance of ibs_swap_glue.
`timescale 1ns/1ps
`default_nettype none
module ibs_glue_monitor (
    // Clock, reset and requests
    input wire logic clk, rst, data_request_n, data_read,
    input wire logic instruction_request_n, instruction_request_type,
    input wire logic [1:0] data_request_type, control_mode_lines_in,
    input wire logic [2:0] option_code, rom_waits,
    input wire logic [31:0] data_address, ibus_in, dbus_in,
    input wire logic align_pin, disable_source_select,
    // Outputs watched
    input wire logic [31:0] ibus_out, dbus_out,
    input wire logic [1:0] control_mode_lines_oe, control_mode_lines_out,
    input wire logic ibus_oe, dbus_oe, transceiver_enable, transceiver_dir,
    input wire logic mem_enable, rom_select, ram_select, rom_ready, mode_normal
);
    // =================================================================
    // Helper logic
    logic [3:0] rom_cnt_r;
    wire logic rom_rd = !data_request_n && data_request_type == 2'h1 &&
        data_read && data_address < 32'h00040000;
    always @(posedge clk or posedge rst) begin
        if (rst)
            rom_cnt_r <= 4'h0;
        else if (!rom_select)
            rom_cnt_r <= 4'h0;
        else if (rom_cnt_r != 4'hf)
            rom_cnt_r <= rom_cnt_r + 4'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // =================================================================
    // Assertions
    a_no_double_drive: assert property (!(ibus_oe && dbus_oe))
        else $error("swap drives both buses");
    a_rom_read_swap: assert property (rom_rd |=> !mem_enable || (dbus_oe
        && transceiver_dir && dbus_out == $past(ibus_in)))
        else $error("rom data read not swapped");
    a_ram_fetch_swap: assert property (!instruction_request_n &&
        instruction_request_type && data_request_n |=> !mem_enable ||
        (ibus_oe && !transceiver_dir && ibus_out == $past(dbus_in)))
        else $error("ram fetch not swapped");
    a_data_ram_direct: assert property (!data_request_n &&
        data_request_type == 2'h0 && instruction_request_n
        |=> !transceiver_enable) else $error("swap on for ram data");
    a_rom_fetch_direct: assert property (!instruction_request_n &&
        !instruction_request_type && data_request_n |=> !transceiver_enable)
        else $error("swap on for rom fetch");
    a_probe_opt_off: assert property (!data_request_n &&
        option_code == 3'h6 && disable_source_select &&
        $past(disable_source_select, 3) |=> !mem_enable)
        else $error("memory on during option probe transfer");
    a_align_off: assert property ((!align_pin &&
        !disable_source_select) [*4] |-> !mem_enable)
        else $error("memory on with align low");
    a_swap_off_disabled: assert property (!mem_enable |->
        !ibus_oe && !dbus_oe) else $error("swap on while memory off");
    a_rom_wait_count: assert property (rom_ready |->
        rom_cnt_r == {1'b0, rom_waits} + 4'h2)
        else $error("rom wait count wrong");
    a_mode_lines_free: assert property ((control_mode_lines_in == 2'h3)
        [*4] |-> mode_normal && control_mode_lines_oe == 2'h0)
        else $error("mode lines driven or not normal");
    a_mode_lines_low: assert property ((control_mode_lines_in != 2'h3)
        [*4] |-> !mode_normal && control_mode_lines_out == 2'h0)
        else $error("mode lines low but reported normal");
    a_select_off_disabled: assert property (!mem_enable |->
        !rom_select && !ram_select)
        else $error("space selected while memory off");
    a_idle_release: assert property (!transceiver_enable |->
        !ibus_oe && !dbus_oe) else $error("bus driven while swap idle");
endmodule
bind ibs_swap_glue ibs_glue_monitor u_mon (.*);
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the swap glue with a bus model.
// Assumes the glue answers a held request with one ready pulse.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, rst = 1, data_request_n = 1, data_read = 1;
    logic instruction_request_n = 1, instruction_request_type = 0;
    logic align_pin = 1, disable_source_select = 0;
    logic [1:0] data_request_type = 0, control_mode_lines_in = 2'h3;
    logic [2:0] option_code = 0, rom_waits = 0, ram_waits = 0;
    logic [31:0] data_address = 0, instruction_address = 0, ipat = 0, dpat = 0;
    wire [31:0] ibus_in, dbus_in, ibus_out, dbus_out, rom_address, ram_address;
    wire [1:0] control_mode_lines_out, control_mode_lines_oe;
    wire ibus_oe, dbus_oe, transceiver_enable, transceiver_dir, mem_enable;
    wire rom_select, ram_select, rom_ready, ram_ready, mode_normal;
    logic [66:0] q[$];
    logic [66:0] e;
    integer seed = 10, num_errors = 0, tests_run = 0, i;
    ibs_swap_glue uut (.*);
    ibs_bus_model bm (.*);
    always #10 clk = ~clk;
    task conclude;
        begin
            $display("Errors: %0d Checks: %0d", num_errors, tests_run);
            if (num_errors == 0 && tests_run > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // Kinds: 0/1 ram read/write, 2/3 rom read/write, 4 rom fetch, 5 ram fetch
    task acc(input int k, input bit hi, input bit ok);
        logic [31:0] a;
        begin
            @(negedge clk);
            a = ($random(seed) & 32'h0000fffc) | (hi ? 32'h00040000 : 0);
            ipat = $random(seed);
            dpat = $random(seed);
            rom_waits = 3'($random(seed));
            ram_waits = 3'($random(seed));
            data_address = a;
            instruction_address = a;
            data_request_n = !(k < 4);
            data_request_type = (k == 2 || k == 3) ? 2'h1 : 2'h0;
            data_read = (k % 2 == 0);
            instruction_request_n = !(k >= 4);
            instruction_request_type = (k == 5);
            if (ok)
                q.push_back({k >= 2 && k <= 4, k == 2 || k == 3 || k == 5,
                    k == 2, k == 2 ? ipat : dpat, a});
            repeat (14) @(negedge clk);
            data_request_n = 1;
            instruction_request_n = 1;
            repeat (2) @(negedge clk);
        end
    endtask
    // Ready pulses stand a full cycle, so the falling edge is race-free
    always @(negedge clk) begin
        if (rom_ready === 1'b1 || ram_ready === 1'b1) begin
            tests_run++;
            if (q.size() == 0) begin
                num_errors++;
                $display("ERROR %0t unexpected ready", $time);
            end else begin
                e = q.pop_front();
                if (rom_ready !== e[66] || transceiver_enable !== e[65] || (e[65]
                    && (transceiver_dir !== e[64] || (e[64] ? dbus_out : ibus_out)
                    !== e[63:32])) || (e[66] ? rom_address : ram_address)
                    !== e[31:0]) begin
                    num_errors++;
                    $display("ERROR %0t transfer mismatch", $time);
                end
            end
        end
    end
    initial begin
        #200000;
        num_errors++;
        $display("ERROR %0t watchdog expired", $time);
        conclude;
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 0;
        repeat (3) @(negedge clk);
        for (i = 0; i < 12; i++)
            acc(i % 6, 0, 1);
        acc(2, 1, 0);
        option_code = 3'h6;
        acc(2, 0, 1);
        align_pin = 0;
        control_mode_lines_in = 2'h1;
        repeat (4) @(negedge clk);
        acc(2, 0, 0);
        acc(5, 0, 0);
        align_pin = 1;
        control_mode_lines_in = 2'h3;
        disable_source_select = 1;
        repeat (4) @(negedge clk);
        acc(2, 0, 0);
        acc(0, 0, 0);
        option_code = 0;
        for (i = 0; i < 6; i++)
            acc(i, 0, 1);
        repeat (4) @(negedge clk);
        tests_run++;
        if (q.size() != 0) begin
            num_errors++;
            $display("ERROR %0t missing ready pulses", $time);
        end
        conclude;
    end
endmodule
`default_nettype wire
